/* sau_serial_chan.sv */
/*
  One serial channel: clocked 3-wire port (master on the system clock,
  slave on the link clock) or single-master two-wire port with software
  start and stop.
  Assumes configuration inputs are static while the unit is enabled and
  that the link clock only runs during slave frames.
*/
`timescale 1ns/10ps

module sau_serial_chan
  import sau_pkg::*;
(
  // System
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic                   sckLink,
  // Configuration
  input  wire logic                   unitPowerEnable,
  input  wire logic                   twoWireMode,
  input  wire logic                   isMaster,
  input  wire logic                   wordLen7,
  input  wire logic                   lsbFirst,
  input  wire logic                   dataPhase,
  input  wire logic                   clockPolarity,
  input  wire logic                   invertData,
  input  wire logic                   irqOnBufEmpty,
  input  wire logic                   serialOutEnable,
  input  wire logic                   i2cReceive,
  input  wire logic [SAU_PRESC_W-1:0] prescSel,
  input  wire logic [SAU_DIV_W-1:0]   divCount,
  // Transmit side
  input  wire logic [7:0]             txData,
  input  wire logic                   txValid,
  output      logic                   txReady,
  // Receive side
  output      logic [7:0]             rxData,
  output      logic                   rxValid,
  input  wire logic                   rxRead,
  // Bus conditions and status
  input  wire logic                   startReq,
  input  wire logic                   stopReq,
  input  wire logic                   errClear,
  output      logic                   busy,
  output      logic                   overrunErr,
  output      logic                   ackErr,
  output      logic                   transferIrq,
  // 3-wire pins
  output      logic                   sckOut,
  output      logic                   sckOeN,
  output      logic                   soOut,
  input  wire logic                   siIn,
  // Two-wire pins
  output      logic                   sclOut,
  output      logic                   sclOeN,
  output      logic                   sdaOut,
  output      logic                   sdaOeN,
  input  wire logic                   sdaIn
);

  // ----------------------------------------------------------------
  // Bit order helpers
  // ----------------------------------------------------------------
  // Puts the first bit to send at bit 7
  function automatic logic [7:0] normTx(input logic [7:0] d, input logic lsb, input logic short7);
    logic [7:0] r;
    r = d;
    for (int i = 0; i < 8; i++)
      if (lsb)
        r[7-i] = d[i];
    if (!lsb && short7)
      r = {d[6:0], 1'b0};
    return r;
  endfunction : normTx

  // First received bit sits at bit len-1
  function automatic logic [7:0] fmtRx(input logic [7:0] s, input logic lsb, input logic short7);
    logic [7:0] r;
    r = short7 ? {1'b0, s[6:0]} : s;
    if (lsb)
    begin
      for (int i = 0; i < 8; i++)
        r[i] = (short7 ? (i < 7 ? s[6-i] : 1'b0) : s[7-i]);
    end
    return r;
  endfunction : fmtRx

  // ----------------------------------------------------------------
  // Rate generator
  // ----------------------------------------------------------------
  sau_tick_if tk ();

  sau_state_t state_r;
  logic       halfTick;

  assign tk.prescSel = prescSel;
  assign tk.divCount = divCount;
  assign tk.run      = unitPowerEnable && (state_r != SAU_IDLE);
  assign halfTick    = tk.halfTick;

  sau_baud uBaud (
    .clock (clock),
    .nrst  (nrst),
    .tk    (tk)
  );

  // ----------------------------------------------------------------
  // Input synchronisers (system domain)
  // ----------------------------------------------------------------
  logic siMeta_r, siSync_r, sdaMeta_r, sdaSync_r;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      siMeta_r  <= 1'b0;
      siSync_r  <= 1'b0;
      sdaMeta_r <= 1'b1;
      sdaSync_r <= 1'b1;
    end
    else
    begin
      siMeta_r  <= siIn;
      siSync_r  <= siMeta_r;
      sdaMeta_r <= sdaIn;
      sdaSync_r <= sdaMeta_r;
    end
  end

  // ----------------------------------------------------------------
  // Shared decode
  // ----------------------------------------------------------------
  logic [SAU_HALF_IDX_W-1:0] halfIdx_r;
  logic [SAU_HALF_IDX_W-1:0] lastHalf3w;
  logic [SAU_HALF_IDX_W-1:0] lastHalfI2c;
  logic [7:0]                txNorm;
  logic                      firstHalf, launch3w, sample3w;
  logic                      mTake, i2cTake, sTake, rxDone3w;

  assign lastHalf3w  = wordLen7 ? SAU_HALF_IDX_W'(2*SAU_WORD_SHORT - 1)
                                : SAU_HALF_IDX_W'(2*SAU_WORD_LONG - 1);
  assign lastHalfI2c = SAU_HALF_IDX_W'(2*SAU_I2C_ACK_SLOT - 1);
  assign txNorm      = normTx(txData, lsbFirst, wordLen7);
  assign firstHalf   = ~halfIdx_r[0];
  // Data phase picks which half launches and which samples
  assign launch3w    = dataPhase ? firstHalf : (~firstHalf && halfIdx_r != lastHalf3w);
  assign sample3w    = dataPhase ? ~firstHalf : firstHalf;
  assign mTake       = unitPowerEnable && isMaster && !twoWireMode && state_r == SAU_IDLE && txValid;
  assign i2cTake     = unitPowerEnable && twoWireMode && state_r == SAU_IDLE && txValid
                       && !startReq && !stopReq;

  // ----------------------------------------------------------------
  // Sequencer (3-wire master and two-wire master)
  // ----------------------------------------------------------------
  logic [7:0] txSh_r, rxSh_r;
  logic       sckLvl_r, mSo_r, sclLow_r, sdaLow_r, rxRecv_r, mDone_r, nack_r;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r   <= SAU_IDLE;
      halfIdx_r <= '0;
      txSh_r    <= SAU_DATA_RST;
      rxSh_r    <= SAU_DATA_RST;
      sckLvl_r  <= SAU_LINE_RST;
      mSo_r     <= SAU_LINE_RST;
      sclLow_r  <= 1'b0;
      sdaLow_r  <= 1'b0;
      rxRecv_r  <= 1'b0;
      mDone_r   <= 1'b0;
      nack_r    <= 1'b0;
    end
    else
    begin
      mDone_r <= 1'b0;
      nack_r  <= 1'b0;
      if (!unitPowerEnable)
      begin
        state_r  <= SAU_IDLE;
        sclLow_r <= 1'b0;
        sdaLow_r <= 1'b0;
      end
      else
      begin
        case (state_r)
          SAU_IDLE:
          begin
            halfIdx_r <= '0;
            sckLvl_r  <= clockPolarity;
            if (twoWireMode && startReq)
              state_r <= SAU_START_A;
            else if (twoWireMode && stopReq)
              state_r <= SAU_STOP_A;
            else if (i2cTake)
            begin
              // Receiving sends all ones so the line stays released
              rxRecv_r <= i2cReceive;
              txSh_r   <= i2cReceive ? 8'hFF : txData;
              sdaLow_r <= i2cReceive ? 1'b0 : ~txData[7];
              state_r  <= SAU_BYTE;
            end
            else if (mTake)
            begin
              txSh_r  <= dataPhase ? txNorm : {txNorm[6:0], 1'b0};
              if (!dataPhase)
                mSo_r <= txNorm[7] ^ invertData;
              state_r <= SAU_SHIFT;
            end
          end
          SAU_SHIFT:
            if (halfTick)
            begin
              sckLvl_r  <= ~sckLvl_r;
              halfIdx_r <= halfIdx_r + SAU_HALF_IDX_W'(1);
              if (launch3w)
              begin
                mSo_r  <= txSh_r[7] ^ invertData;
                txSh_r <= {txSh_r[6:0], 1'b0};
              end
              if (sample3w)
                rxSh_r <= {rxSh_r[6:0], siSync_r ^ invertData};
              if (halfIdx_r == lastHalf3w)
              begin
                mDone_r <= 1'b1;
                state_r <= SAU_IDLE;
              end
            end
          SAU_START_A:
            if (halfTick)
            begin
              sclLow_r <= 1'b0;
              sdaLow_r <= 1'b0;
              state_r  <= SAU_START_B;
            end
          SAU_START_B:
            if (halfTick)
            begin
              sdaLow_r <= 1'b1;
              state_r  <= SAU_START_C;
            end
          SAU_START_C:
            if (halfTick)
            begin
              sclLow_r <= 1'b1;
              state_r  <= SAU_IDLE;
            end
          SAU_BYTE:
            if (halfTick)
            begin
              halfIdx_r <= halfIdx_r + SAU_HALF_IDX_W'(1);
              if (firstHalf)
                sclLow_r <= 1'b0;
              else
              begin
                sclLow_r <= 1'b1;
                if (halfIdx_r == lastHalfI2c)
                begin
                  // Ninth clock: acknowledge sampled, then line released
                  nack_r   <= !rxRecv_r && sdaSync_r;
                  sdaLow_r <= 1'b0;
                  mDone_r  <= 1'b1;
                  state_r  <= SAU_IDLE;
                end
                else
                begin
                  rxSh_r <= {rxSh_r[6:0], sdaSync_r};
                  if (halfIdx_r == SAU_HALF_IDX_W'(2*SAU_I2C_BITS - 1))
                    sdaLow_r <= rxRecv_r && serialOutEnable;
                  else
                    sdaLow_r <= ~txSh_r[6];
                  txSh_r <= {txSh_r[6:0], 1'b1};
                end
              end
            end
          SAU_STOP_A:
            if (halfTick)
            begin
              sclLow_r <= 1'b1;
              sdaLow_r <= 1'b1;
              state_r  <= SAU_STOP_B;
            end
          SAU_STOP_B:
            if (halfTick)
            begin
              sclLow_r <= 1'b0;
              state_r  <= SAU_STOP_C;
            end
          SAU_STOP_C:
            if (halfTick)
            begin
              sdaLow_r <= 1'b0;
              state_r  <= SAU_IDLE;
            end
          default:
            state_r <= SAU_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // 3-wire slave, link clock domain
  // ----------------------------------------------------------------
  // Fixed format: launch on falling edge, sample on rising edge
  logic [7:0] txHold_r, sTxSh_r, sRx_r, sRxWord_r;
  logic [2:0] sCnt_r;
  logic       sSo_r, sTakeTog_r, sDoneTog_r;
  logic [2:0] sLast;
  logic [7:0] txHoldNorm;

  assign sLast      = wordLen7 ? 3'(SAU_WORD_SHORT - 1) : 3'(SAU_WORD_LONG - 1);
  // Held word put in send order; stable while pending, so safe to read here
  assign txHoldNorm = normTx(txHold_r, lsbFirst, wordLen7);

  // Sample side counts bits and hands a finished word over by toggle
  always_ff @(posedge sckLink or negedge nrst)
  begin
    if (!nrst)
    begin
      sCnt_r     <= 3'h0;
      sRx_r      <= SAU_DATA_RST;
      sRxWord_r  <= SAU_DATA_RST;
      sDoneTog_r <= 1'b0;
    end
    else
    begin
      sRx_r <= {sRx_r[6:0], siIn ^ invertData};
      if (sCnt_r == sLast)
      begin
        sCnt_r     <= 3'h0;
        sRxWord_r  <= fmtRx({sRx_r[6:0], siIn ^ invertData}, lsbFirst, wordLen7);
        sDoneTog_r <= ~sDoneTog_r;
      end
      else
        sCnt_r <= sCnt_r + 3'h1;
    end
  end

  // Launch side takes the held word at each word boundary
  always_ff @(negedge sckLink or negedge nrst)
  begin
    if (!nrst)
    begin
      sSo_r      <= SAU_LINE_RST;
      sTxSh_r    <= SAU_DATA_RST;
      sTakeTog_r <= 1'b0;
    end
    else if (sCnt_r == 3'h0)
    begin
      sSo_r      <= txHoldNorm[7] ^ invertData;
      sTxSh_r    <= {txHoldNorm[6:0], 1'b0};
      sTakeTog_r <= ~sTakeTog_r;
    end
    else
    begin
      sSo_r   <= sTxSh_r[7] ^ invertData;
      sTxSh_r <= {sTxSh_r[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Crossing back to the system domain
  // ----------------------------------------------------------------
  logic [2:0] takeSync_r, doneSync_r;
  logic       txPend_r, sDoneEv;

  // Third stage only feeds the edge detector, never the first
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      takeSync_r <= 3'h0;
      doneSync_r <= 3'h0;
    end
    else
    begin
      takeSync_r <= {takeSync_r[1:0], sTakeTog_r};
      doneSync_r <= {doneSync_r[1:0], sDoneTog_r};
    end
  end

  assign sTake   = takeSync_r[2] ^ takeSync_r[1];
  assign sDoneEv = doneSync_r[2] ^ doneSync_r[1];
  assign rxDone3w = (mDone_r && !twoWireMode) || sDoneEv;

  // Holding word for the slave; stable while pending
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      txHold_r <= 8'hFF;
      txPend_r <= 1'b0;
    end
    else if (!isMaster && !twoWireMode && txValid && !txPend_r)
    begin
      txHold_r <= txData;
      txPend_r <= 1'b1;
    end
    else if (sTake)
      txPend_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Receive word, flags and event pulse
  // ----------------------------------------------------------------
  logic       wordDone, ovr_r, ack_r, irq_r, rxValid_r;
  logic [7:0] rxData_r;

  assign wordDone = rxDone3w || (mDone_r && twoWireMode);

  // Set wins over software clear on every flag
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rxData_r  <= SAU_DATA_RST;
      rxValid_r <= 1'b0;
      ovr_r     <= 1'b0;
      ack_r     <= 1'b0;
      irq_r     <= 1'b0;
    end
    else
    begin
      if (wordDone)
        rxData_r <= sDoneEv ? sRxWord_r
                  : (twoWireMode ? rxSh_r : fmtRx(rxSh_r, lsbFirst, wordLen7));
      rxValid_r <= wordDone || (rxValid_r && !rxRead);
      ovr_r     <= (rxDone3w && rxValid_r && !rxRead) || (ovr_r && !errClear);
      ack_r     <= nack_r || (ack_r && !errClear);
      irq_r     <= (!twoWireMode && irqOnBufEmpty) ? (mTake || sTake)
                                                   : wordDone;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign txReady     = unitPowerEnable && (twoWireMode ? i2cTake
                       : (isMaster ? mTake : !txPend_r));
  assign rxData      = rxData_r;
  assign rxValid     = rxValid_r;
  assign busy        = (state_r != SAU_IDLE) || txPend_r;
  assign overrunErr  = ovr_r;
  assign ackErr      = ack_r;
  assign transferIrq = irq_r;
  // 3-wire: clock driven only as master, data held high when output is disabled
  assign sckOut      = sckLvl_r;
  assign sckOeN      = ~(unitPowerEnable && isMaster && !twoWireMode);
  assign soOut       = !serialOutEnable ? 1'b1 : (isMaster ? mSo_r : sSo_r);
  // Two-wire lines are open drain: pull low or release
  assign sclOut      = 1'b0;
  // Clock line is never read back: no stretching or arbitration handling
  assign sclOeN      = ~(twoWireMode && sclLow_r);
  assign sdaOut      = 1'b0;
  assign sdaOeN      = ~(twoWireMode && sdaLow_r);

endmodule : sau_serial_chan

/* sau_pkg.sv */
/*
  Shared constants and types for the serial unit channel: timing limits,
  word lengths, bit slots and the sequencer state type.
  Assumes every design file imports the whole package.
*/
package sau_pkg;

  // ----------------------------------------------------------------
  // Widths of the bit-rate settings
  // ----------------------------------------------------------------
  localparam int SAU_PRESC_W         = 4;
  localparam int SAU_DIV_W           = 8;

  // ----------------------------------------------------------------
  // Timing limits
  // ----------------------------------------------------------------
  localparam int SAU_MASTER_MIN_CLKS = 4;    // Least system clocks per master serial clock
  localparam int SAU_MIN_HALF_CLKS   = (SAU_MASTER_MIN_CLKS + 1) / 2;
  localparam int SAU_SLAVE_RATIO     = 6;    // Slave clock limit as a fraction of the unit clock

  // ----------------------------------------------------------------
  // Word lengths and bit slots
  // ----------------------------------------------------------------
  localparam int SAU_WORD_LONG       = 8;
  localparam int SAU_WORD_SHORT      = 7;
  localparam int SAU_I2C_BITS        = 8;
  localparam int SAU_I2C_ACK_SLOT    = 9;    // Clock that carries the acknowledge
  localparam int SAU_HALF_IDX_W      = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SAU_DATA_RST = 8'h00;
  localparam logic       SAU_LINE_RST = 1'b1;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum {
    SAU_IDLE,
    SAU_SHIFT,
    SAU_START_A,
    SAU_START_B,
    SAU_START_C,
    SAU_BYTE,
    SAU_STOP_A,
    SAU_STOP_B,
    SAU_STOP_C
  } sau_state_t;

endpackage : sau_pkg

/* sau_tick_if.sv */
/*
  Carrier between the channel and its bit-rate generator: the rate
  settings going down and the half-bit tick coming back.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps

interface sau_tick_if
  import sau_pkg::*;
();
  logic [SAU_PRESC_W-1:0] prescSel;
  logic [SAU_DIV_W-1:0]   divCount;
  logic                   run;
  logic                   halfTick;

  modport gen (input prescSel, input divCount, input run, output halfTick);
  modport use_ (output prescSel, output divCount, output run, input halfTick);
endinterface : sau_tick_if

/* sau_baud.sv */
/*
  Bit-rate generator: a power-of-two prescaler followed by a per-channel
  divider; emits one pulse per half serial bit.
  Assumes settings are held steady while run is high.
*/
`timescale 1ns/10ps

module sau_baud
  import sau_pkg::*;
(
  // System
  input  wire logic clock,
  input  wire logic nrst,
  // Rate settings and tick
  sau_tick_if.gen   tk
);

  // ----------------------------------------------------------------
  // Prescaler and divider
  // ----------------------------------------------------------------
  logic [15:0]          preCnt_r;
  logic [SAU_DIV_W-1:0] divCnt_r;
  logic [15:0]          preLast;
  logic [SAU_DIV_W-1:0] divEff;
  logic                 preEnd;
  logic                 divEnd;

  // The divider floor keeps a master clock period at four system clocks or more
  assign preLast = (16'h0001 << tk.prescSel) - 16'h0001;
  assign preEnd  = (preCnt_r == preLast);
  assign divEff  = (tk.prescSel == '0 && tk.divCount < SAU_DIV_W'(SAU_MIN_HALF_CLKS - 1))
                   ? SAU_DIV_W'(SAU_MIN_HALF_CLKS - 1) : tk.divCount;
  assign divEnd  = (divCnt_r >= divEff);
  assign tk.halfTick = tk.run & preEnd & divEnd;

  // Prescaler counts system clocks
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      preCnt_r <= 16'h0000;
    else if (!tk.run || preEnd)
      preCnt_r <= 16'h0000;
    else
      preCnt_r <= preCnt_r + 16'h0001;
  end

  // Divider counts prescaler outputs
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      divCnt_r <= '0;
    else if (!tk.run || tk.halfTick)
      divCnt_r <= '0;
    else if (preEnd)
      divCnt_r <= divCnt_r + SAU_DIV_W'(1);
  end

endmodule : sau_baud

/* sau_chk.sv */
/* Port checker for the serial channel.
   Assumes it is bound to sau_serial_chan by name. */
`timescale 1ns/10ps
module sau_chk
(
  // Watched ports
  input wire logic clock, nrst, busy, txReady, txValid, transferIrq, rxValid, errClear, overrunErr, ackErr,
  input wire logic sckOut, soOut, sdaOeN, isMaster, twoWireMode, clockPolarity, unitPowerEnable,
  input wire logic serialOutEnable, startReq, stopReq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // Master 3-wire in use
  wire m3 = isMaster && !twoWireMode && unitPowerEnable;
  // Two-wire idle with no software request
  sequence quiet2;
    (!busy && !startReq && !stopReq && !txValid && twoWireMode)[*2];
  endsequence
  AST_READY: assert property (busy |-> !txReady) else $error("ready while busy");
  AST_IRQ: assert property (transferIrq |=> !transferIrq) else $error("irq too long");
  AST_SCK_HALF: assert property (m3 && $changed(sckOut) |=> $stable(sckOut)) else $error("sck too fast");
  AST_SCK_IDLE: assert property ((m3 && !busy && $stable(clockPolarity))[*3] |-> sckOut == clockPolarity)
    else $error("sck idle level");
  AST_OVR_SET: assert property ($rose(overrunErr) |-> $past(rxValid)) else $error("overrun w/o word");
  AST_OVR_HOLD: assert property (overrunErr && !errClear |=> overrunErr) else $error("overrun lost");
  AST_ACK_HOLD: assert property (ackErr && !errClear |=> ackErr) else $error("ack flag lost");
  AST_CLR: assert property (errClear && !busy && !twoWireMode |=> !overrunErr) else $error("flag kept");
  AST_SO_OFF: assert property ((!serialOutEnable && !twoWireMode)[*2] |-> soOut) else $error("so driven");
  AST_NO_AUTO: assert property (quiet2 |=> $stable(sdaOeN)) else $error("sda moved");
endmodule : sau_chk

/* sau_peer.sv */
/* Far side: an echoing 3-wire peripheral and a pulled-up two-wire bus
   with no target answering. Assumes low-active open-drain enables. */
`timescale 1ns/10ps
module sau_peer
(
  // 3-wire lines
  input  wire logic so,
  output      logic si,
  // Two-wire data line
  input  wire logic sdaOeN,
  output      logic sda
);
  // Echo: the received word equals the sent one cut to the word length, while serial output is enabled
  assign si = so;
  // Pull-up only, so every target acknowledge is missing
  assign sda = sdaOeN;
endmodule : sau_peer

/* sau_tb.sv */
/* Bench: master echo over all formats, a link-clock slave frame, overrun,
   two-wire start, send, receive, stop. Assumes checker and peer compiled. */
`timescale 1ns/10ps
module testbench;
  import sau_pkg::*;
  logic clock = 0, nrst = 0, sckLink = 1, unitPowerEnable = 1, twoWireMode = 0, isMaster = 1, wordLen7 = 0;
  logic lsbFirst = 0, dataPhase = 0, clockPolarity = 0, invertData = 0, irqOnBufEmpty = 0, serialOutEnable = 1;
  logic i2cReceive = 0, txValid = 0, rxRead = 0, startReq = 0, stopReq = 0, errClear = 0, siB = 1, siP, siIn;
  logic [SAU_PRESC_W-1:0] prescSel = 0;
  logic [SAU_DIV_W-1:0]   divCount = 2;
  logic [7:0]             txData = 0, rxData, d;
  logic txReady, rxValid, busy, overrunErr, ackErr, transferIrq, sckOut, sckOeN, soOut;
  logic sclOut, sclOeN, sdaOut, sdaOeN, sdaIn;
  integer seed = 32'heada7aa9, err_count = 0, total_checks = 0, i, k, lowCnt = 0, base;
  assign siIn = isMaster ? siP : siB;
  sau_serial_chan u_dut (.*);
  sau_peer u_peer (.so(soOut), .si(siP), .sdaOeN(sdaOeN), .sda(sdaIn));
  always #20 clock = ~clock;
  // Cycles with data pulled low, to see acknowledges
  always @(posedge clock) if (!sdaOeN) lowCnt <= lowCnt + 1;
  task tick(input integer n); repeat (n) @(posedge clock); #1; endtask : tick
  task chk(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function logic [7:0] expw(input logic [7:0] v);
    return (serialOutEnable ? v : (invertData ? 8'h00 : 8'hFF)) & (wordLen7 ? 8'h7F : 8'hFF);
  endfunction : expw
  // Hold the request until a settled ready has been seen at an edge
  task put(input logic [7:0] v);
    txData = v; txValid = 1;
    for (k = 0; k < 400; k++) begin #18; if (txReady === 1) break; tick(1); end
    tick(1); txValid = 0;
  endtask : put
  task waitRx; for (k = 0; k < 3000 && rxValid !== 1; k++) tick(1); endtask : waitRx
  task waitIdle; for (k = 0; k < 3000 && busy !== 0; k++) tick(1); endtask : waitIdle
  task rdPulse; rxRead = 1; tick(1); rxRead = 0; endtask : rdPulse
  task finish_test;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  initial begin #4000000; err_count++; finish_test; end
  initial
  begin
    tick(2); nrst = 1; tick(4);
    // Every format combination, echoed back through the peer
    for (i = 0; i < 64; i++)
    begin
      {irqOnBufEmpty, invertData, clockPolarity, dataPhase, lsbFirst, wordLen7} = 6'(i);
      serialOutEnable = (i % 5 != 4); prescSel = 4'(i % 3 == 2); divCount = 8'(2 + ($random(seed) & 3));
      d = (i < 2) ? {8{i[0]}} : 8'($random(seed));
      tick(3); put(d); waitRx;
      chk(rxData, expw(d));
      rdPulse; waitIdle;
    end
    // Second word unread: overrun, then cleared
    serialOutEnable = 1; put(8'h3C); waitRx; put(8'hC3); waitIdle; tick(3);
    chk(8'(overrunErr), 8'h01);
    chk(rxData, expw(8'hC3));
    errClear = 1; tick(1); errClear = 0; rdPulse; chk(8'(overrunErr), 8'h00);
    // Slave frame on the link clock, MSB first
    {isMaster, irqOnBufEmpty, wordLen7, lsbFirst, invertData} = 0; d = 8'($random(seed)); tick(2); put(8'h5A);
    for (i = 7; i >= 0; i--) begin #15 sckLink = 0; siB = d[i]; #15 sckLink = 1; end
    #15 siB = ~siB; tick(1); waitRx;
    chk(rxData, d);
    rdPulse; waitIdle;
    // Two-wire: start, address with no answer, two receives, stop
    twoWireMode = 1; isMaster = 1; tick(2); startReq = 1; tick(1); startReq = 0; waitIdle;
    put(8'hA4); waitIdle; tick(2); chk(8'(ackErr), 8'h01);
    i2cReceive = 1; base = lowCnt; put(8'hFF); waitIdle; tick(2); chk(rxData, 8'hFF);
    chk(8'(lowCnt != base), 8'h01);
    serialOutEnable = 0; base = lowCnt; put(8'hFF); waitIdle; chk(8'(lowCnt != base), 8'h00);
    stopReq = 1; tick(1); stopReq = 0; waitIdle; tick(4); chk(8'(sdaOeN), 8'h01);
    finish_test;
  end
endmodule : testbench
bind sau_serial_chan sau_chk u_chk (.*);
